/* File: hdl/hs_interrupt_uframe_sched_status.sv */
// Microframe scheduler and per-slot result store for high-speed interrupt transfers
//
// Design decisions made here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module hs_interrupt_uframe_sched_status
(
   input  wire logic                                  mclk_i,
   input  wire logic                                  nrst_i,
   input  wire logic                                  wb_cyc_i,
   input  wire logic                                  wb_stb_i,
   input  wire logic                                  wb_we_i,
   input  wire logic [hs_int_sched_pkg::ADR_W-1:0]    wb_adr_i,
   input  wire logic [hs_int_sched_pkg::SEL_W-1:0]    wb_sel_i,
   input  wire logic [hs_int_sched_pkg::DAT_W-1:0]    wb_dat_i,
   output logic [hs_int_sched_pkg::DAT_W-1:0]         wb_dat_o,
   output logic                                       wb_ack_o,
   input  wire logic                                  sof_i,
   input  wire logic [hs_int_sched_pkg::FNUM_W-1:0]   frame_num_i,
   input  wire logic [hs_int_sched_pkg::SLOT_W-1:0]   uframe_i,
   output logic                                       txn_req_o,
   output logic [hs_int_sched_pkg::SLOT_W-1:0]        txn_slot_o,
   output logic                                       txn_in_o,
   input  wire logic                                  txn_done_i,
   input  wire logic                                  txn_err_i,
   input  wire logic                                  txn_babble_i,
   input  wire logic                                  txn_underrun_i,
   output logic                                       irq_o
);

   typedef enum logic [0:0] {ST_IDLE, ST_BUSY} sched_state_e;

   localparam int unsigned SLOTS  = hs_int_sched_pkg::SLOTS;
   localparam int unsigned RES_W  = hs_int_sched_pkg::RES_W;
   localparam int unsigned IRQ_W  = hs_int_sched_pkg::IRQ_W;
   localparam int unsigned TWO_W  = hs_int_sched_pkg::TWO_W;

   sched_state_e                       state_q;
   logic [SLOTS-1:0]                   mask_q;
   logic [SLOTS*RES_W-1:0]             results_q;
   logic [TWO_W-1:0]                   word_two_q;
   logic [hs_int_sched_pkg::CTRL_W-1:0] ctrl_q;
   logic [hs_int_sched_pkg::SLOT_W-1:0] slot_q;
   logic                               dir_in_q;
   logic                               ack_q;
   logic [hs_int_sched_pkg::DAT_W-1:0] dat_q;
   logic [IRQ_W-1:0]                   irq_stat;
   logic [IRQ_W-1:0]                   irq_mask;
   logic [IRQ_W-1:0]                   irq_set;
   logic [IRQ_W-1:0]                   irq_clr;
   logic [RES_W-1:0]                   res_now;
   logic                               bus_acc;
   logic                               bus_done;
   logic                               wr_done;
   logic                               rd_done;
   logic                               byte0_wr;
   logic                               txn_fin;
   logic                               frame_hit;
   logic                               slot_armed;
   logic [SLOTS-1:0]                   sw_set;
   logic [SLOTS-1:0]                   hw_clr;
   // Next values, issue decision and per-register strobes
   logic [SLOTS-1:0]                   mask_d;
   logic [SLOTS*RES_W-1:0]             results_d;
   logic                               busy;
   logic                               issue;
   logic                               wr_four;
   logic                               wr_two;
   logic                               wr_ctrl;
   logic                               wr_mask;
   logic                               rd_stat;

   // Frame field of zero means every frame; else the low frame bits must match
   function automatic logic frame_match
   (
      input logic [hs_int_sched_pkg::FRAME_W-1:0] field,
      input logic [hs_int_sched_pkg::FNUM_W-1:0]  fnum
   );
      logic hit;
      hit = (field == '0) || (field == fnum[hs_int_sched_pkg::FRAME_W-1:0]);
      return hit;
   endfunction

   // Access strobe aimed at one register offset
   function automatic logic reg_hit
   (
      input logic                               strobe,
      input logic [hs_int_sched_pkg::ADR_W-1:0] adr,
      input logic [hs_int_sched_pkg::ADR_W-1:0] off
   );
      logic hit;
      hit = strobe && (adr == off);
      return hit;
   endfunction

   // Read view of each register; unmapped reads zero
   function automatic logic [hs_int_sched_pkg::DAT_W-1:0] read_word
   (
      input logic [hs_int_sched_pkg::ADR_W-1:0] adr
   );
      logic [hs_int_sched_pkg::DAT_W-1:0] v;
      v = hs_int_sched_pkg::ZERO_W;
      unique case (adr)
         hs_int_sched_pkg::OFF_WORD_FOUR:
         begin
            v[hs_int_sched_pkg::MASK_LSB +: SLOTS] = mask_q;
            v[hs_int_sched_pkg::RES_LSB +: SLOTS*RES_W] = results_q;
         end
         hs_int_sched_pkg::OFF_WORD_TWO:
            v[TWO_W-1:0] = word_two_q;
         hs_int_sched_pkg::OFF_CTRL:
            v[hs_int_sched_pkg::CTRL_W-1:0] = ctrl_q;
         hs_int_sched_pkg::OFF_INT_STAT:
            v[IRQ_W-1:0] = irq_stat;
         hs_int_sched_pkg::OFF_INT_MASK:
            v[IRQ_W-1:0] = irq_mask;
         hs_int_sched_pkg::OFF_STATE:
         begin
            v[hs_int_sched_pkg::STATE_BUSY_BIT] = (state_q == ST_BUSY);
            v[hs_int_sched_pkg::STATE_SLOT_LSB +: hs_int_sched_pkg::SLOT_W] = slot_q;
         end
         default:
            v = hs_int_sched_pkg::ZERO_W;
      endcase
      return v;
   endfunction

   // Bus strobes: writes and read side effects land on the edge that sees ack
   assign bus_acc  = wb_cyc_i & wb_stb_i;
   assign bus_done = bus_acc & ack_q;
   assign wr_done  = bus_done & wb_we_i;
   assign rd_done  = bus_done & ~wb_we_i;
   assign byte0_wr = wr_done & wb_sel_i[0];

   // Per-register strobes; every writable field sits in byte lane zero
   assign wr_four = reg_hit(byte0_wr, wb_adr_i, hs_int_sched_pkg::OFF_WORD_FOUR);
   assign wr_two  = reg_hit(byte0_wr, wb_adr_i, hs_int_sched_pkg::OFF_WORD_TWO);
   assign wr_ctrl = reg_hit(byte0_wr, wb_adr_i, hs_int_sched_pkg::OFF_CTRL);
   assign wr_mask = reg_hit(byte0_wr, wb_adr_i, hs_int_sched_pkg::OFF_INT_MASK);
   assign rd_stat = reg_hit(rd_done, wb_adr_i, hs_int_sched_pkg::OFF_INT_STAT);

   // Single registered ack, one wait state, drops the cycle after
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         ack_q <= 1'b0;
      else
         ack_q <= bus_acc & ~ack_q;
   end

   // Read data captured with the ack so it stands while ack is high
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         dat_q <= hs_int_sched_pkg::ZERO_W;
      else if (bus_acc & ~ack_q)
         dat_q <= read_word(wb_adr_i);
   end

   // Bus outputs straight from flops
   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

   // Descriptor word two, frame field steers the scheduler
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         word_two_q <= hs_int_sched_pkg::TWO_RST;
      else if (wr_two)
         word_two_q <= wb_dat_i[TWO_W-1:0];
   end

   // Control: enable and direction of the endpoint
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         ctrl_q <= hs_int_sched_pkg::CTRL_RST;
      else if (wr_ctrl)
         ctrl_q <= wb_dat_i[hs_int_sched_pkg::CTRL_W-1:0];
   end

   // Slot mask: software ORs in ones, hardware clears the handled slot
   assign sw_set = wr_four ?
                   wb_dat_i[hs_int_sched_pkg::MASK_LSB +: SLOTS] : hs_int_sched_pkg::MASK_RST;
   assign txn_fin = busy & txn_done_i;
   assign hw_clr  = txn_fin ? hs_int_sched_pkg::slot_onehot(slot_q) : hs_int_sched_pkg::MASK_RST;

   // A re-arm in the finishing cycle wins so a new request is not dropped
   always_comb
   begin
      mask_d = mask_q & ~hw_clr;
      mask_d = mask_d | sw_set;
   end

   // Slot mask register
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         mask_q <= hs_int_sched_pkg::MASK_RST;
      else
         mask_q <= mask_d;
   end

   // Outcome encoding of the finishing transaction
   slot_result_encode u_encode
   (
      .dir_in_i   (dir_in_q),
      .err_i      (txn_err_i),
      .babble_i   (txn_babble_i),
      .underrun_i (txn_underrun_i),
      .result_o   (res_now)
   );

   // Result of a slot written when its transaction ends, slot 7 on top
   always_comb
   begin
      results_d = results_q;
      if (txn_fin)
         results_d[slot_q*RES_W +: RES_W] = res_now;
   end

   // Results register; software has no way to clear it
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         results_q <= hs_int_sched_pkg::RES_RST;
      else
         results_q <= results_d;
   end

   // Issue decision at each microframe start
   assign frame_hit  = frame_match(word_two_q[hs_int_sched_pkg::FRAME_LSB +:
                                   hs_int_sched_pkg::FRAME_W], frame_num_i);
   assign slot_armed = mask_q[uframe_i];
   assign busy       = (state_q == ST_BUSY);
   assign issue      = sof_i & ctrl_q[hs_int_sched_pkg::CTRL_EN_BIT] & frame_hit &
                       slot_armed & ~busy;

   // Scheduler: one transaction in flight; a start while busy is counted a miss
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         state_q <= ST_IDLE;
      else
      begin
         unique case (state_q)
            ST_IDLE:
               if (issue)
                  state_q <= ST_BUSY;
            ST_BUSY:
               if (txn_done_i)
                  state_q <= ST_IDLE;
         endcase
      end
   end

   // Slot of the issued transaction, held until its done
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         slot_q <= '0;
      else if (issue)
         slot_q <= uframe_i;
   end

   // Direction latched at issue so a control write mid-flight cannot skew the result
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         dir_in_q <= 1'b0;
      else if (issue)
         dir_in_q <= ctrl_q[hs_int_sched_pkg::CTRL_IN_BIT];
   end

   // Link outputs come straight from flops
   assign txn_req_o  = busy;
   assign txn_slot_o = slot_q;
   assign txn_in_o   = dir_in_q;

   // Events; read clears only the bits that were reported
   always_comb
   begin
      irq_set = hs_int_sched_pkg::IRQ_RST;
      irq_set[hs_int_sched_pkg::IRQ_DONE_BIT] = txn_fin;
      irq_set[hs_int_sched_pkg::IRQ_ERR_BIT]  = txn_fin & (|res_now);
      irq_set[hs_int_sched_pkg::IRQ_MISS_BIT] = sof_i & busy;
   end

   // Read clears only what that read returned, so an event in flight is kept
   assign irq_clr = rd_stat ? dat_q[IRQ_W-1:0] :
                    hs_int_sched_pkg::IRQ_RST;

   // Sticky events, mask and level line
   irq_sticky #(.W(IRQ_W)) u_irq
   (
      .mclk_i     (mclk_i),
      .nrst_i     (nrst_i),
      .set_i      (irq_set),
      .clr_i      (irq_clr),
      .mask_wr_i  (wr_mask),
      .mask_dat_i (wb_dat_i[IRQ_W-1:0]),
      .status_o   (irq_stat),
      .mask_o     (irq_mask),
      .irq_o      (irq_o)
   );

endmodule
`default_nettype wire

/* File: inc/hs_int_sched_pkg.sv */
// Constants, field layout and register map of the interrupt microframe scheduler
// How it works
// - Each of eight slots gets a 3-bit result, slot 7 highest, after completion
// - Result bit0 error any direction, bit1 babble IN only, bit2 underrun OUT only
// - Transactions issue only when frame field is zero or matches bus frame, and slot bit set
// - All mask bits set issues a transaction in every microframe of the frame
// - Every fourth mask bit set issues a transaction every fourth microframe
`default_nettype none
package hs_int_sched_pkg;

   // Bus geometry
   localparam int unsigned ADR_W  = 8;
   localparam int unsigned DAT_W  = 32;
   localparam int unsigned SEL_W  = 4;

   // Register byte offsets
   localparam logic [7:0] OFF_WORD_FOUR = 8'h00;
   localparam logic [7:0] OFF_WORD_TWO  = 8'h04;
   localparam logic [7:0] OFF_CTRL      = 8'h08;
   localparam logic [7:0] OFF_INT_STAT  = 8'h0C;
   localparam logic [7:0] OFF_INT_MASK  = 8'h10;
   localparam logic [7:0] OFF_STATE     = 8'h14;

   // Descriptor word four layout
   localparam int unsigned SLOTS     = 8;
   localparam int unsigned SLOT_W    = 3;
   localparam int unsigned MASK_LSB  = 0;
   localparam int unsigned RES_W     = 3;
   localparam int unsigned RES_LSB   = 8;
   localparam int unsigned RES_ERR_BIT      = 0;
   localparam int unsigned RES_BABBLE_BIT   = 1;
   localparam int unsigned RES_UNDERRUN_BIT = 2;

   // Descriptor word two layout
   localparam int unsigned TWO_W     = 8;
   localparam int unsigned FRAME_LSB = 3;
   localparam int unsigned FRAME_W   = 5;
   localparam int unsigned FNUM_W    = 11;

   // Control bits
   localparam int unsigned CTRL_W      = 2;
   localparam int unsigned CTRL_EN_BIT = 0;
   localparam int unsigned CTRL_IN_BIT = 1;

   // Interrupt events
   localparam int unsigned IRQ_W        = 3;
   localparam int unsigned IRQ_DONE_BIT = 0;
   localparam int unsigned IRQ_ERR_BIT  = 1;
   localparam int unsigned IRQ_MISS_BIT = 2;

   // State register fields
   localparam int unsigned STATE_BUSY_BIT = 0;
   localparam int unsigned STATE_SLOT_LSB = 1;

   // Reset values
   localparam logic [SLOTS-1:0]       MASK_RST = 8'h00;
   localparam logic [SLOTS*RES_W-1:0] RES_RST  = 24'h000000;
   localparam logic [TWO_W-1:0]       TWO_RST  = 8'h00;
   localparam logic [CTRL_W-1:0]      CTRL_RST = 2'h0;
   localparam logic [IRQ_W-1:0]       IRQ_RST  = 3'h0;
   localparam logic [DAT_W-1:0]       ZERO_W   = 32'h00000000;

   // One-hot mask for a slot index
   function automatic logic [SLOTS-1:0] slot_onehot(input logic [SLOT_W-1:0] slot);
      logic [SLOTS-1:0] v;
      v = MASK_RST;
      v[slot] = 1'b1;
      return v;
   endfunction

endpackage
`default_nettype wire

/* File: hdl/slot_result_encode.sv */
// Encodes one transaction outcome into a 3-bit slot result
`timescale 1ns/100ps
`default_nettype none
module slot_result_encode
(
   input  wire logic       dir_in_i,
   input  wire logic       err_i,
   input  wire logic       babble_i,
   input  wire logic       underrun_i,
   output logic [2:0]      result_o
);

   // Babble only counts on IN, underrun only on OUT
   always_comb
   begin
      result_o = 3'h0;
      result_o[hs_int_sched_pkg::RES_ERR_BIT]      = err_i;
      result_o[hs_int_sched_pkg::RES_BABBLE_BIT]   = babble_i & dir_in_i;
      result_o[hs_int_sched_pkg::RES_UNDERRUN_BIT] = underrun_i & ~dir_in_i;
   end

endmodule
`default_nettype wire

/* File: hdl/irq_sticky.sv */
// Sticky interrupt status with read-clear, mask and level output
`timescale 1ns/100ps
`default_nettype none
module irq_sticky
#(
   parameter int unsigned W = 3
)
(
   input  wire logic         mclk_i,
   input  wire logic         nrst_i,
   input  wire logic [W-1:0] set_i,
   input  wire logic [W-1:0] clr_i,
   input  wire logic         mask_wr_i,
   input  wire logic [W-1:0] mask_dat_i,
   output logic [W-1:0]      status_o,
   output logic [W-1:0]      mask_o,
   output logic              irq_o
);

   // Set beats clear so an event landing on a read is kept
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         status_o <= '0;
      else
         status_o <= (status_o & ~clr_i) | set_i;
   end

   // Mask written whole by software
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         mask_o <= '0;
      else if (mask_wr_i)
         mask_o <= mask_dat_i;
   end

   assign irq_o = |(status_o & mask_o);

endmodule
`default_nettype wire

/* File: testbench/hs_int_sched_assertions.sv */
// Port-level checks for the interrupt microframe scheduler
`timescale 1ns/100ps
`default_nettype none
module hs_int_sched_assertions
(
   input wire logic                                mclk_i,
   input wire logic                                nrst_i,
   input wire logic                                wb_cyc_i,
   input wire logic                                wb_stb_i,
   input wire logic                                wb_ack_o,
   input wire logic                                sof_i,
   input wire logic [hs_int_sched_pkg::SLOT_W-1:0] uframe_i,
   input wire logic                                txn_req_o,
   input wire logic [hs_int_sched_pkg::SLOT_W-1:0] txn_slot_o,
   input wire logic                                txn_done_i
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);

   // Issue is caused by a microframe start, in that microframe's slot
   a_start_needs_sof: assert property ($rose(txn_req_o) |-> $past(sof_i))
      else $error("transaction started without microframe start");
   a_slot_from_uframe: assert property ($rose(txn_req_o) |-> txn_slot_o == $past(uframe_i))
      else $error("transaction slot differs from microframe");
   // Completion ends the slot; no second issue from the same handling
   a_done_ends_txn: assert property (txn_req_o && txn_done_i |=> !txn_req_o)
      else $error("transaction still pending after done");
   a_txn_holds: assert property (txn_req_o && !txn_done_i |=> txn_req_o && $stable(txn_slot_o))
      else $error("pending transaction dropped or moved");
   a_sof_busy_ignored: assert property (
      txn_req_o && !txn_done_i && sof_i |=> txn_req_o && $stable(txn_slot_o))
      else $error("microframe start disturbed a busy transaction");
   // Bus answers one cycle after a request, for one cycle
   a_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not acknowledged");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("acknowledge longer than one cycle");
endmodule

bind hs_interrupt_uframe_sched_status hs_int_sched_assertions u_chk
(
   .mclk_i, .nrst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .sof_i,
   .uframe_i, .txn_req_o, .txn_slot_o, .txn_done_i
);
`default_nettype wire

/* File: testbench/usb_int_endpoint_model.sv */
// Behavioural interrupt endpoint answering scheduled transactions
`timescale 1ns/100ps
`default_nettype none
module usb_int_endpoint_model
(
   input  wire logic       mclk_i,
   input  wire logic       nrst_i,
   input  wire logic       req_i,
   input  wire logic [3:0] delay_i,
   input  wire logic [2:0] flags_i,
   output logic            done_o,
   output logic [2:0]      outcome_o
);
   logic [3:0] wait_q;

   // One done pulse delay_i+1 cycles after req_i rises; 0 answers on the next cycle
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         wait_q <= 4'h0;
         done_o <= 1'h0;
      end
      else
      begin
         done_o <= 1'h0;
         if (req_i && !done_o)
         begin
            wait_q <= (wait_q == delay_i) ? 4'h0 : wait_q + 4'h1;
            done_o <= (wait_q == delay_i);
         end
      end
   end

   // Outcome means nothing without done, so show garbage then
   assign outcome_o = done_o ? flags_i : ~flags_i;
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
// Self-checking bench for the interrupt microframe scheduler
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic        mclk_i, nrst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, sof_i, irq_o;
   logic        txn_req_o, txn_in_o, txn_done_i;
   logic [7:0]  wb_adr_i;
   logic [3:0]  wb_sel_i, ep_delay;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic [10:0] frame_num_i;
   logic [2:0]  uframe_i, txn_slot_o, ep_flags, outc;
   logic [23:0] e;
   int          fail_count, samples_checked, cycles;

   hs_interrupt_uframe_sched_status u_dut
   (
      .mclk_i, .nrst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .sof_i, .frame_num_i, .uframe_i,
      .txn_req_o, .txn_slot_o, .txn_in_o, .txn_done_i, .txn_err_i(outc[0]),
      .txn_babble_i(outc[1]), .txn_underrun_i(outc[2]), .irq_o
   );

   usb_int_endpoint_model u_ep
   (
      .mclk_i, .nrst_i, .req_i(txn_req_o), .delay_i(ep_delay),
      .flags_i(ep_flags), .done_o(txn_done_i), .outcome_o(outc)
   );

   // Free-running 100 MHz clock
   initial
   begin
      mclk_i = 1'h0;
      forever #5 mclk_i = ~mclk_i;
   end

   // Hang guard, well above the run length
   always @(posedge mclk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fail_count++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Classic cycle: hold until ack, then one idle cycle
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'hF;
      wb_dat_i <= wd;
      do
      begin
         @(posedge mclk_i);
      end
      while (wb_ack_o !== 1'h1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      @(posedge mclk_i);
   endtask

   task automatic rdc(input logic [7:0] adr, input logic [31:0] exp);
      wb(1'h0, adr, 32'h0);
      chk(rd, exp);
   endtask

   // One microframe start; watch whether and how a transaction issues
   task automatic tick(input logic [10:0] fr, input logic [2:0] uf, input logic iss, input logic din);
      logic seen;
      logic [2:0] sl;
      logic dir;
      seen = 1'h0;
      sof_i <= 1'h1;
      frame_num_i <= fr;
      uframe_i <= uf;
      @(posedge mclk_i);
      sof_i <= 1'h0;
      repeat (12)
      begin
         @(posedge mclk_i);
         if (txn_req_o === 1'h1 && !seen)
         begin
            seen = 1'h1;
            sl = txn_slot_o;
            dir = txn_in_o;
         end
      end
      chk(32'(seen), 32'(iss));
      if (iss)
      begin
         chk(32'(sl), 32'(uf));
         chk(32'(dir), 32'(din));
      end
   endtask

   task automatic t_reset();
      rdc(8'h00, 32'h0);
      rdc(8'h3C, 32'h0);
      chk(32'(irq_o), 32'h0);
   endtask

   task automatic t_all_slots();
      ep_flags <= 3'h7;
      ep_delay <= 4'h0;
      wb(1'h1, 8'h08, 32'h3);
      wb(1'h1, 8'h04, 32'h0);
      wb(1'h1, 8'h10, 32'h7);
      wb(1'h1, 8'h00, 32'hFF);
      for (int u = 0; u < 8; u++)
         tick(11'(u * 37), 3'(u), 1'h1, 1'h1);
      rdc(8'h00, {{8{3'h3}}, 8'h00});
   endtask

   task automatic t_irq();
      chk(32'(irq_o), 32'h1);
      wb(1'h1, 8'h10, 32'h0);
      chk(32'(irq_o), 32'h0);
      wb(1'h1, 8'h10, 32'h7);
      chk(32'(irq_o), 32'h1);
      rdc(8'h0C, 32'h3);
      rdc(8'h0C, 32'h0);
      chk(32'(irq_o), 32'h0);
   endtask

   // Every-fourth pattern with frame field zero, then one slot in a matched frame
   task automatic t_fourth();
      ep_flags <= 3'h6;
      ep_delay <= 4'h5;
      wb(1'h1, 8'h08, 32'h1);
      wb(1'h1, 8'h00, 32'h11);
      wb(1'h1, 8'h00, 32'h0);
      rdc(8'h00, {{8{3'h3}}, 8'h11});
      for (int u = 0; u < 8; u++)
         tick(11'h404, 3'(u), u % 4 == 0, 1'h0);
      wb(1'h1, 8'h04, 32'h28);
      wb(1'h1, 8'h00, 32'h04);
      for (int u = 0; u < 8; u++)
         tick(11'h404, 3'(u), 1'h0, 1'h0);
      for (int u = 0; u < 8; u++)
         tick(11'h045, 3'(u), u == 2, 1'h0);
      e = {8{3'h3}};
      e[2:0] = 3'h4;
      e[8:6] = 3'h4;
      e[14:12] = 3'h4;
      rdc(8'h00, {e, 8'h00});
   endtask

   // A start while busy is refused, flagged as a miss, and leaves its slot armed
   task automatic t_miss();
      ep_delay <= 4'hF;
      wb(1'h1, 8'h04, 32'h0);
      rdc(8'h0C, 32'h3);
      wb(1'h1, 8'h00, 32'h06);
      sof_i <= 1'h1;
      frame_num_i <= 11'h001;
      uframe_i <= 3'h1;
      @(posedge mclk_i);
      sof_i <= 1'h0;
      @(posedge mclk_i);
      sof_i <= 1'h1;
      uframe_i <= 3'h2;
      @(posedge mclk_i);
      sof_i <= 1'h0;
      rdc(8'h14, 32'h3);
      repeat (20) @(posedge mclk_i);
      e[5:3] = 3'h4;
      rdc(8'h00, {e, 8'h04});
      rdc(8'h0C, 32'h7);
   endtask

   // Reset for two cycles, then the scenarios in turn
   initial
   begin
      fail_count = 0;
      samples_checked = 0;
      cycles = 0;
      nrst_i = 1'h0;
      wb_cyc_i = 1'h0;
      wb_stb_i = 1'h0;
      wb_we_i = 1'h0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'hF;
      wb_dat_i = 32'h0;
      sof_i = 1'h0;
      frame_num_i = 11'h000;
      uframe_i = 3'h0;
      ep_delay = 4'h0;
      ep_flags = 3'h0;
      repeat (2) @(posedge mclk_i);
      nrst_i <= 1'h1;
      @(posedge mclk_i);
      t_reset();
      t_all_slots();
      t_irq();
      t_fourth();
      t_miss();
      print_verdict();
   end
endmodule
`default_nettype wire
